// [common/epc_pkg.sv]
// Shared constants for the E1 performance counter and interrupt mask block.
// Assumes an 8-bit parallel control port and a 2.048 Mbit/s receive bit strobe.
package epc_pkg;

    // ************************************************************
    // Register offsets on the parallel control port
    // ************************************************************
    localparam logic [7:0] VIOLATION_COUNT_HIGH_OFS     = 8'h00;
    localparam logic [7:0] VIOLATION_COUNT_LOW_OFS      = 8'h01;
    localparam logic [7:0] CRC_ERROR_COUNT_HIGH_OFS     = 8'h02;
    localparam logic [7:0] CRC_ERROR_COUNT_LOW_OFS      = 8'h03;
    localparam logic [7:0] FAR_END_ERROR_COUNT_HIGH_OFS = 8'h04;
    localparam logic [7:0] FAR_END_ERROR_COUNT_LOW_OFS  = 8'h05;
    localparam logic [7:0] RECEIVE_ALARM_IRQ_MASK_OFS   = 8'h16;
    localparam logic [7:0] FRAME_EVENT_IRQ_MASK_OFS     = 8'h17;

    // ************************************************************
    // Reset values and read filler
    // ************************************************************
    localparam logic [7:0] IRQ_MASK_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ  = 8'h00;

    // ************************************************************
    // Counter widths
    // ************************************************************
    localparam int VIOLATION_COUNT_W = 16;
    localparam int CRC_COUNT_W       = 10;
    localparam int FAR_END_COUNT_W   = 10;
    localparam int FAS_COUNT_W       = 12;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int INTERVAL_TIMER_STATUS_BIT = 4;
    localparam int EBIT_FRAME_A              = 13;
    localparam int EBIT_FRAME_B              = 15;
    localparam int HDB3_ZEROS_BEFORE_V       = 2;

    // ************************************************************
    // Interval timing, counted in received bits
    // ************************************************************
    localparam longint LINE_RATE_HZ        = 2048000;
    localparam longint LONG_INTERVAL_US    = 1000000;
    localparam longint SHORT_INTERVAL_US   = 62500;
    localparam longint LONG_INTERVAL_BITS  = LINE_RATE_HZ * LONG_INTERVAL_US / 64'd1000000;
    localparam longint SHORT_INTERVAL_BITS = LINE_RATE_HZ * SHORT_INTERVAL_US / 64'd1000000;

endpackage

// [rtl/epc_sat_counter.sv]
// Saturating event accumulator with a snapshot register.
// Assumes inc_i and latch_i are single-cycle strobes on CLK_I.
`timescale 1ns/100ps
module epc_sat_counter #(
    parameter int W = 16
) (
    input  wire logic         clk_i,
    input  wire logic         rstn_i,
    input  wire logic         inc_i,
    input  wire logic         latch_i,
    output logic      [W-1:0] snap_o
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [W-1:0] acc;
        logic [W-1:0] snap;
    } epc_cnt_state_t;

    localparam logic [W-1:0] ALL_ONES = {W{1'b1}};

    epc_cnt_state_t s_q;
    epc_cnt_state_t s_d;

    always_comb
    begin
        s_d = s_q;
        if (latch_i)
        begin
            // Event in the latch cycle opens the new interval
            s_d.snap = s_q.acc;
            s_d.acc  = inc_i ? {{(W-1){1'b0}}, 1'b1} : '0;
        end
        else if (inc_i && s_q.acc != ALL_ONES)
        begin
            s_d.acc = s_q.acc + {{(W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign snap_o = s_q.snap;

endmodule

// [rtl/epc_top.sv]
// E1 performance counters, interval timer and interrupt masking.
// Assumes all framer inputs are strobes or levels on CLK_I, and that
// RX_BIT_STB_I pulses once per received line bit.
`timescale 1ns/100ps

// How it works
// - Alarm mask bit one enables that interrupt
// - Event mask bit one enables that interrupt
// - Counters latch each second or 62.5ms
// - Counters hold at maximum, never wrap
// - 16-bit violation count at 0x00, 0x01
// - Mode zero counts same-polarity consecutive marks
// - HDB3 substitution violations are not counted
// - Mode one counts same-polarity repeated violations
// - Violation count ignores sync loss
// - 10-bit CRC count at 0x02, 0x03
// - Upper 0x02 bits carry FAS count top
// - CRC, E-bit stop on FAS/CRC sync loss
// - Count zero E-bits in frames 13, 15
// - E-bit at 0x04, 0x05; FAS low bits above
// - Interval flag set each second or 62.5ms
module epc_top #(
    parameter longint LONG_INTERVAL_BITS  = epc_pkg::LONG_INTERVAL_BITS,
    parameter longint SHORT_INTERVAL_BITS = epc_pkg::SHORT_INTERVAL_BITS
) (
    input  wire logic       CLK_I,
    input  wire logic       RSTN_I,
    // Parallel control port
    input  wire logic [7:0] ADDR_I,
    input  wire logic [7:0] DATA_I,
    input  wire logic       WR_I,
    input  wire logic       RD_I,
    output logic      [7:0] DATA_O,
    // Configuration levels
    input  wire logic       INTERVAL_SELECT_I,
    input  wire logic       VIOLATION_MODE_SELECT_I,
    input  wire logic       RX_HDB3_ENABLE_I,
    // Receive line bits
    input  wire logic       RX_BIT_STB_I,
    input  wire logic       RX_POS_I,
    input  wire logic       RX_NEG_I,
    // Framer events
    input  wire logic       CRC_ERR_STB_I,
    input  wire logic       FAS_ERR_STB_I,
    input  wire logic       SI_BIT_STB_I,
    input  wire logic       SI_BIT_I,
    input  wire logic [3:0] RX_FRAME_NUM_I,
    input  wire logic       FAS_SYNC_LOSS_I,
    input  wire logic       CRC_MF_SYNC_LOSS_I,
    input  wire logic       CAS_MF_SYNC_LOSS_I,
    // Status flags from the status register logic
    input  wire logic [7:0] RX_ALARM_FLAGS_I,
    input  wire logic [7:0] FRAME_EVENT_FLAGS_I,
    input  wire logic       INTERVAL_FLAG_CLR_I,
    output logic            INTERVAL_FLAG_O,
    output logic            INTERVAL_TICK_O,
    output logic            INT_O
);

    // ************************************************************
    // Widths and limits
    // ************************************************************
    localparam int IVL_W = $clog2(LONG_INTERVAL_BITS + 1);

    localparam logic [IVL_W-1:0] LONG_LAST  = IVL_W'(LONG_INTERVAL_BITS - 1);
    localparam logic [IVL_W-1:0] SHORT_LAST = IVL_W'(SHORT_INTERVAL_BITS - 1);
    localparam logic [IVL_W-1:0] IVL_ONE    = IVL_W'(1);

    localparam int VW = epc_pkg::VIOLATION_COUNT_W;
    localparam int CW = epc_pkg::CRC_COUNT_W;
    localparam int EW = epc_pkg::FAR_END_COUNT_W;
    localparam int FW = epc_pkg::FAS_COUNT_W;

    localparam logic [1:0] ZERO_RUN_MAX = 2'd3;
    localparam logic [1:0] HDB3_ZEROS   = 2'(epc_pkg::HDB3_ZEROS_BEFORE_V);
    localparam logic [3:0] EBIT_A       = 4'(epc_pkg::EBIT_FRAME_A);
    localparam logic [3:0] EBIT_B       = 4'(epc_pkg::EBIT_FRAME_B);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [7:0]       alarm_mask;
        logic [7:0]       event_mask;
        logic [7:0]       rd_data;
        logic             irq;
        logic [IVL_W-1:0] ivl_cnt;
        logic             ivl_tick;
        logic             ivl_flag;
        logic             have_mark;
        logic             last_mark_neg;
        logic             have_bpv;
        logic             last_bpv_neg;
        logic [1:0]       zero_run;
    } epc_state_t;

    epc_state_t s_q;
    epc_state_t s_d;

    // ************************************************************
    // Snapshot registers from the accumulators
    // ************************************************************
    logic [VW-1:0] vio_snap;
    logic [CW-1:0] crc_snap;
    logic [EW-1:0] ebit_snap;
    logic [FW-1:0] fas_snap;

    logic mark;
    logic mark_neg;
    logic bpv;
    logic hdb3_sub;
    logic cv;
    logic vio_inc;
    logic sync_ok;
    logic crc_inc;
    logic ebit_inc;
    logic fas_inc;
    logic [7:0] event_flags;
    logic [7:0] alarm_hits;
    logic [7:0] event_hits;
    logic [7:0] rd_mux;
    logic [IVL_W-1:0] ivl_last;

    // ************************************************************
    // Line violation detection
    // ************************************************************
    // A mark that repeats the polarity of the previous mark is a bipolar violation.
    assign mark     = RX_BIT_STB_I && (RX_POS_I ^ RX_NEG_I);
    assign mark_neg = RX_NEG_I;
    assign bpv      = mark && s_q.have_mark && (mark_neg == s_q.last_mark_neg);

    // The V pulse of 000V or B00V always follows at least two zeros.
    assign hdb3_sub = bpv && RX_HDB3_ENABLE_I && (s_q.zero_run >= HDB3_ZEROS);

    // Code violation: this violation has the polarity of the last violation.
    assign cv = bpv && s_q.have_bpv && (mark_neg == s_q.last_bpv_neg);

    // Never gated by sync state; the line may be unframed.
    assign vio_inc = VIOLATION_MODE_SELECT_I ? cv : (bpv && !hdb3_sub);

    // ************************************************************
    // Framed error sources
    // ************************************************************
    // Loss of signaling multiframe sync alone does not stop these counts.
    assign sync_ok  = !FAS_SYNC_LOSS_I && !CRC_MF_SYNC_LOSS_I;
    assign crc_inc  = CRC_ERR_STB_I && sync_ok;
    assign ebit_inc = SI_BIT_STB_I && !SI_BIT_I && sync_ok
                      && (RX_FRAME_NUM_I == EBIT_A || RX_FRAME_NUM_I == EBIT_B);
    assign fas_inc  = FAS_ERR_STB_I && !FAS_SYNC_LOSS_I;

    // ************************************************************
    // Interrupt flag set
    // ************************************************************
    always_comb
    begin
        event_flags = FRAME_EVENT_FLAGS_I;
        event_flags[epc_pkg::INTERVAL_TIMER_STATUS_BIT] = s_q.ivl_flag;
    end

    // Each mask gates only its own flag group
    assign alarm_hits = RX_ALARM_FLAGS_I & s_q.alarm_mask;
    assign event_hits = event_flags & s_q.event_mask;

    // ************************************************************
    // Interval limit
    // ************************************************************
    // Picked live, so a new interval select acts at the next strobe
    // A longer limit simply lets the running interval continue
    assign ivl_last = INTERVAL_SELECT_I ? SHORT_LAST : LONG_LAST;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb
    begin
        s_d = s_q;
        s_d.ivl_tick = 1'b0;

        // Interval timer on received bits
        if (RX_BIT_STB_I)
        begin
            // A shortened limit after a mode change still ends the interval
            if (s_q.ivl_cnt >= ivl_last)
            begin
                s_d.ivl_cnt  = '0;
                s_d.ivl_tick = 1'b1;
            end
            else
            begin
                s_d.ivl_cnt = s_q.ivl_cnt + IVL_ONE;
            end
        end

        // Set wins over a clear in the same cycle
        if (s_q.ivl_tick)
            s_d.ivl_flag = 1'b1;
        else if (INTERVAL_FLAG_CLR_I)
            s_d.ivl_flag = 1'b0;

        // Line history
        if (RX_BIT_STB_I)
        begin
            if (mark)
            begin
                s_d.have_mark     = 1'b1;
                s_d.last_mark_neg = mark_neg;
                s_d.zero_run      = 2'd0;
            end
            else if (s_q.zero_run != ZERO_RUN_MAX)
            begin
                s_d.zero_run = s_q.zero_run + 2'd1;
            end
        end
        if (bpv)
        begin
            s_d.have_bpv     = 1'b1;
            s_d.last_bpv_neg = mark_neg;
        end

        // Mask register writes
        if (WR_I)
        begin
            if (ADDR_I == epc_pkg::RECEIVE_ALARM_IRQ_MASK_OFS)
                s_d.alarm_mask = DATA_I;
            else if (ADDR_I == epc_pkg::FRAME_EVENT_IRQ_MASK_OFS)
                s_d.event_mask = DATA_I;
        end

        // Register reads, answered one cycle later
        if (RD_I)
            s_d.rd_data = rd_mux;

        // Level interrupt, drops once no enabled flag remains
        s_d.irq = (|alarm_hits)
                  || (|event_hits);
    end

    // ************************************************************
    // Read decode
    // ************************************************************
    // Halves of a count are not paired; both come from one snapshot,
    // so the host must fetch them within one interval.
    // Unmapped offsets read as the filler value and never fault.
    always_comb
    begin
        if (ADDR_I == epc_pkg::VIOLATION_COUNT_HIGH_OFS)
            rd_mux = vio_snap[15:8];
        else if (ADDR_I == epc_pkg::VIOLATION_COUNT_LOW_OFS)
            rd_mux = vio_snap[7:0];
        else if (ADDR_I == epc_pkg::CRC_ERROR_COUNT_HIGH_OFS)
            rd_mux = {fas_snap[11:6], crc_snap[9:8]};
        else if (ADDR_I == epc_pkg::CRC_ERROR_COUNT_LOW_OFS)
            rd_mux = crc_snap[7:0];
        else if (ADDR_I == epc_pkg::FAR_END_ERROR_COUNT_HIGH_OFS)
            rd_mux = {fas_snap[5:0], ebit_snap[9:8]};
        else if (ADDR_I == epc_pkg::FAR_END_ERROR_COUNT_LOW_OFS)
            rd_mux = ebit_snap[7:0];
        else if (ADDR_I == epc_pkg::RECEIVE_ALARM_IRQ_MASK_OFS)
            rd_mux = s_q.alarm_mask;
        else if (ADDR_I == epc_pkg::FRAME_EVENT_IRQ_MASK_OFS)
            rd_mux = s_q.event_mask;
        else
            rd_mux = epc_pkg::UNMAPPED_READ;
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge CLK_I)
    begin
        if (!RSTN_I)
        begin
            s_q            <= '0;
            s_q.alarm_mask <= epc_pkg::IRQ_MASK_RESET;
            s_q.event_mask <= epc_pkg::IRQ_MASK_RESET;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ************************************************************
    // Accumulators, all latched on the same tick
    // ************************************************************
    // Snapshots are overwritten on every tick; software must read in time.
    epc_sat_counter #(
        .W (VW)
    ) u_vio_cnt (
        .clk_i   (CLK_I),
        .rstn_i  (RSTN_I),
        .inc_i   (vio_inc),
        .latch_i (s_q.ivl_tick),
        .snap_o  (vio_snap)
    );

    epc_sat_counter #(
        .W (CW)
    ) u_crc_cnt (
        .clk_i   (CLK_I),
        .rstn_i  (RSTN_I),
        .inc_i   (crc_inc),
        .latch_i (s_q.ivl_tick),
        .snap_o  (crc_snap)
    );

    epc_sat_counter #(
        .W (EW)
    ) u_ebit_cnt (
        .clk_i   (CLK_I),
        .rstn_i  (RSTN_I),
        .inc_i   (ebit_inc),
        .latch_i (s_q.ivl_tick),
        .snap_o  (ebit_snap)
    );

    epc_sat_counter #(
        .W (FW)
    ) u_fas_cnt (
        .clk_i   (CLK_I),
        .rstn_i  (RSTN_I),
        .inc_i   (fas_inc),
        .latch_i (s_q.ivl_tick),
        .snap_o  (fas_snap)
    );

    // ************************************************************
    // Outputs
    // ************************************************************
    assign DATA_O          = s_q.rd_data;
    assign INTERVAL_FLAG_O = s_q.ivl_flag;
    assign INTERVAL_TICK_O = s_q.ivl_tick;
    assign INT_O           = s_q.irq;

    // CAS multiframe sync loss is deliberately unused by these counters.
    logic cas_unused;
    assign cas_unused = CAS_MF_SYNC_LOSS_I;

endmodule

// [testbench/epc_monitor.sv]
// Concurrent checks on the ports of the E1 performance counter block.
// Assumes it is bound to epc_top and that the interval select changes only in reset.
`timescale 1ns/100ps
module epc_monitor #(
    parameter longint LONG_INTERVAL_BITS  = 40,
    parameter longint SHORT_INTERVAL_BITS = 10
) (
    input  wire logic       CLK_I,
    input  wire logic       RSTN_I,
    input  wire logic [7:0] ADDR_I,
    input  wire logic [7:0] DATA_I,
    input  wire logic       WR_I,
    input  wire logic       RD_I,
    input  wire logic [7:0] DATA_O,
    input  wire logic       INTERVAL_SELECT_I,
    input  wire logic       RX_BIT_STB_I,
    input  wire logic [7:0] RX_ALARM_FLAGS_I,
    input  wire logic [7:0] FRAME_EVENT_FLAGS_I,
    input  wire logic       INTERVAL_FLAG_CLR_I,
    input  wire logic       INTERVAL_FLAG_O,
    input  wire logic       INTERVAL_TICK_O,
    input  wire logic       INT_O
);
    // ************************************************************
    // Shadow masks and strobe count
    // ************************************************************
    logic [7:0] m1_q;
    logic [7:0] m2_q;
    longint     cnt_q;
    longint     lim;
    assign lim = INTERVAL_SELECT_I ? SHORT_INTERVAL_BITS : LONG_INTERVAL_BITS;
    // A strobe in the tick cycle already belongs to the new interval
    always_ff @(posedge CLK_I)
    begin
        if (!RSTN_I)
        begin
            m1_q  <= 8'h00;
            m2_q  <= 8'h00;
            cnt_q <= 0;
        end
        else
        begin
            if (WR_I && ADDR_I == 8'h16)
                m1_q <= DATA_I;
            if (WR_I && ADDR_I == 8'h17)
                m2_q <= DATA_I;
            cnt_q <= (INTERVAL_TICK_O ? 0 : cnt_q) + longint'(RX_BIT_STB_I);
        end
    end
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RSTN_I);
    AST_INT_FOLLOWS:
        assert property (1'b1 |=> INT_O == $past(|{RX_ALARM_FLAGS_I & m1_q,
            FRAME_EVENT_FLAGS_I & m2_q & 8'hef, INTERVAL_FLAG_O & m2_q[4]}))
        else $error("interrupt does not follow flags and masks");
    AST_TICK_AT_LIMIT:
        assert property (INTERVAL_TICK_O |-> cnt_q == lim)
        else $error("interval tick not at the bit count");
    AST_NO_OVERRUN:
        assert property (cnt_q <= lim)
        else $error("interval ran past its bit count");
    AST_FLAG_SETS:
        assert property (INTERVAL_TICK_O |=> INTERVAL_FLAG_O)
        else $error("interval flag not set after tick");
    AST_FLAG_HOLDS:
        assert property (INTERVAL_FLAG_O && !INTERVAL_FLAG_CLR_I |=> INTERVAL_FLAG_O)
        else $error("interval flag dropped without clear");
    AST_FLAG_CLEARS:
        assert property (INTERVAL_FLAG_CLR_I && !INTERVAL_TICK_O |=> !INTERVAL_FLAG_O)
        else $error("interval flag not cleared");
    AST_FLAG_CAUSE:
        assert property ($rose(INTERVAL_FLAG_O) |-> $past(INTERVAL_TICK_O))
        else $error("interval flag rose without tick");
    AST_READ_HOLDS:
        assert property (!$past(RD_I) |-> $stable(DATA_O))
        else $error("read data changed without a read");
    AST_MASK_READ:
        assert property (RD_I && ADDR_I[7:1] == 7'h0b |=> DATA_O == $past(ADDR_I[0] ? m2_q : m1_q))
        else $error("mask read back wrong");
    AST_UNMAPPED:
        assert property (RD_I && ADDR_I > 8'h05 && ADDR_I[7:1] != 7'h0b |=> DATA_O == 8'h00)
        else $error("unmapped read not zero");
endmodule
bind epc_top epc_monitor #(
    .LONG_INTERVAL_BITS(LONG_INTERVAL_BITS),
    .SHORT_INTERVAL_BITS(SHORT_INTERVAL_BITS)
) u_mon (
    .CLK_I(CLK_I), .RSTN_I(RSTN_I), .ADDR_I(ADDR_I), .DATA_I(DATA_I), .WR_I(WR_I), .RD_I(RD_I),
    .DATA_O(DATA_O), .INTERVAL_SELECT_I(INTERVAL_SELECT_I), .RX_BIT_STB_I(RX_BIT_STB_I),
    .RX_ALARM_FLAGS_I(RX_ALARM_FLAGS_I), .FRAME_EVENT_FLAGS_I(FRAME_EVENT_FLAGS_I),
    .INTERVAL_FLAG_CLR_I(INTERVAL_FLAG_CLR_I), .INTERVAL_FLAG_O(INTERVAL_FLAG_O),
    .INTERVAL_TICK_O(INTERVAL_TICK_O), .INT_O(INT_O)
);

// [testbench/epc_line_model.sv]
// Receive line and frame bit model on the framer side of the counter block.
// Assumes callers step on falling edges of clk_i, one request at a time.
`timescale 1ns/100ps
module epc_line_model (
    input  wire logic       clk_i,
    output logic            bit_stb_o,
    output logic            pos_o,
    output logic            neg_o,
    output logic            si_stb_o,
    output logic            si_o,
    output logic [3:0]      frame_o
);
    // ************************************************************
    // Strobed line bits and frame bits
    // ************************************************************
    initial
    begin
        {bit_stb_o, pos_o, neg_o, si_stb_o, si_o, frame_o} = 9'h000;
    end
    // Between strobes the lines show the inverse, so stale values never count
    task automatic send(input logic [1:0] m);
        @(negedge clk_i);
        bit_stb_o = 1'b1;
        {pos_o, neg_o} = m;
        @(negedge clk_i);
        bit_stb_o = 1'b0;
        {pos_o, neg_o} = ~m;
    endtask
    task automatic si(input logic [3:0] f, input logic b);
        @(negedge clk_i);
        si_stb_o = 1'b1;
        {si_o, frame_o} = {b, f};
        @(negedge clk_i);
        si_stb_o = 1'b0;
        {si_o, frame_o} = ~{b, f};
    endtask
endmodule

// [testbench/e1_perf_counters_irq_mask_bench.sv]
// Self-checking bench for the E1 performance counter and mask block.
// Assumes short interval parameters so each interval is 40 or 10 bits.
`timescale 1ns/100ps
module e1_perf_counters_irq_mask_bench;
    localparam longint LONG_BITS  = 40;
    localparam longint SHORT_BITS = 10;
    logic        clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, fclr = 1'b0;
    logic        isel = 1'b0, vmode = 1'b0, hdb3 = 1'b0, crc_stb = 1'b0, fas_stb = 1'b0;
    logic        fas_loss = 1'b0, crc_loss = 1'b0, cas_loss = 1'b0, tick_seen = 1'b0;
    logic [7:0]  addr = 8'h00, wdat = 8'h00, rdat;
    logic [15:0] flg = 16'h0000;
    logic        iflag, tick, irq, bit_stb, pos, neg, si_stb, si;
    logic [3:0]  fnum;
    int          n_errors = 0;
    int          checks_done = 0;
    epc_top #(.LONG_INTERVAL_BITS(LONG_BITS), .SHORT_INTERVAL_BITS(SHORT_BITS)) u_dut (
        .CLK_I(clk), .RSTN_I(rstn), .ADDR_I(addr), .DATA_I(wdat), .WR_I(wr), .RD_I(rd), .DATA_O(rdat),
        .INTERVAL_SELECT_I(isel), .VIOLATION_MODE_SELECT_I(vmode), .RX_HDB3_ENABLE_I(hdb3),
        .RX_BIT_STB_I(bit_stb), .RX_POS_I(pos), .RX_NEG_I(neg), .CRC_ERR_STB_I(crc_stb),
        .FAS_ERR_STB_I(fas_stb), .SI_BIT_STB_I(si_stb), .SI_BIT_I(si), .RX_FRAME_NUM_I(fnum),
        .FAS_SYNC_LOSS_I(fas_loss), .CRC_MF_SYNC_LOSS_I(crc_loss), .CAS_MF_SYNC_LOSS_I(cas_loss),
        .RX_ALARM_FLAGS_I(flg[7:0]), .FRAME_EVENT_FLAGS_I(flg[15:8]), .INTERVAL_FLAG_CLR_I(fclr),
        .INTERVAL_FLAG_O(iflag), .INTERVAL_TICK_O(tick), .INT_O(irq)
    );
    epc_line_model u_line (.clk_i(clk), .bit_stb_o(bit_stb), .pos_o(pos), .neg_o(neg),
        .si_stb_o(si_stb), .si_o(si), .frame_o(fnum));
    initial
    begin
        forever #2 clk = ~clk;
    end
    always @(posedge clk)
        if (tick === 1'b1)
            tick_seen <= 1'b1;
    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic rst(input logic s, input logic v, input logic h);
        @(negedge clk);
        rstn = 1'b0;
        {isel, vmode, hdb3, flg} = {s, v, h, 16'h0000};
        repeat (2) @(negedge clk);
        rstn = 1'b1;
    endtask
    task automatic pulse(ref logic s);
        @(negedge clk);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        {addr, wdat, wr} = {a, d, 1'b1};
        @(negedge clk);
        wr = 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        {addr, rd} = {a, 1'b1};
        @(negedge clk);
        rd = 1'b0;
        @(negedge clk);
        cmp($sformatf("register %h", a), {8'h00, e}, {8'h00, rdat});
    endtask
    task automatic marks(input logic [15:0] s, input int n);
        for (int k = n - 1; k >= 0; k--)
            u_line.send(s[2*k +: 2]);
    endtask
    // Zero bits until the next tick, then let the snapshots land
    task automatic wait_tick();
        int n;
        n = 0;
        tick_seen = 1'b0;
        while (tick_seen !== 1'b1 && n < 100)
        begin
            u_line.send(2'b00);
            n++;
        end
        if (tick_seen !== 1'b1)
        begin
            n_errors++;
            $display("mismatch interval tick expected 1 seen 0");
            conclude();
        end
        repeat (3) @(negedge clk);
    endtask
    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic test_masks();
        logic [15:0] m;
        rst(1'b0, 1'b0, 1'b0);
        rd_chk(8'h16, 8'h00);
        rd_chk(8'h17, 8'h00);
        for (int i = 0; i < 16; i++)
        begin
            m = 16'h0001 << i;
            wr_reg(8'h16, m[7:0]);
            wr_reg(8'h17, m[15:8]);
            flg = m;
            repeat (3) @(negedge clk);
            cmp("interrupt enabled", (i == 12) ? 16'h0000 : 16'h0001, irq);
            flg = ~m;
            repeat (3) @(negedge clk);
            cmp("interrupt masked", 16'h0000, irq);
        end
        flg = 16'h0000;
        rd_chk(8'h17, 8'h80);
        wr_reg(8'h01, 8'hff);
        rd_chk(8'h01, 8'h00);
        rd_chk(8'h3c, 8'h00);
        $display("test masks done");
    endtask
    task automatic test_counts();
        logic [7:0] e [6];
        e = '{8'h00, 8'h02, 8'h00, 8'h02, 8'h04, 8'h02};
        rst(1'b0, 1'b0, 1'b0);
        marks(16'b100101, 3);
        fas_loss = 1'b1;
        marks(16'b1010, 2);
        pulse(crc_stb);
        pulse(fas_stb);
        u_line.si(4'hd, 1'b0);
        {fas_loss, crc_loss} = 2'b01;
        pulse(crc_stb);
        u_line.si(4'hf, 1'b0);
        {crc_loss, cas_loss} = 2'b01;
        pulse(crc_stb);
        pulse(crc_stb);
        u_line.si(4'hd, 1'b0);
        u_line.si(4'hf, 1'b0);
        u_line.si(4'he, 1'b0);
        u_line.si(4'hd, 1'b1);
        cas_loss = 1'b0;
        pulse(fas_stb);
        wait_tick();
        for (int a = 0; a < 6; a++)
            rd_chk(8'(a), e[a]);
        cmp("interval flag", 16'h0001, iflag);
        wr_reg(8'h17, 8'h10);
        repeat (3) @(negedge clk);
        cmp("interval interrupt", 16'h0001, irq);
        pulse(fclr);
        repeat (3) @(negedge clk);
        cmp("cleared interrupt", 16'h0000, irq);
        wait_tick();
        rd_chk(8'h01, 8'h00);
        rd_chk(8'h03, 8'h00);
        $display("test counts done");
    endtask
    task automatic test_hdb3();
        rst(1'b0, 1'b0, 1'b1);
        marks(16'b1000001001_01, 6);
        wait_tick();
        rd_chk(8'h01, 8'h01);
        $display("test hdb3 done");
    endtask
    task automatic test_cv();
        rst(1'b1, 1'b1, 1'b0);
        marks(16'b1010010101, 5);
        wait_tick();
        rd_chk(8'h01, 8'h01);
        $display("test code violations done");
    endtask
    task automatic test_saturate();
        rst(1'b0, 1'b0, 1'b0);
        repeat (1030) pulse(crc_stb);
        repeat (1030) u_line.si(4'hd, 1'b0);
        wait_tick();
        rd_chk(8'h02, 8'h03);
        rd_chk(8'h03, 8'hff);
        rd_chk(8'h04, 8'h03);
        rd_chk(8'h05, 8'hff);
        $display("test saturation done");
    endtask
    initial
    begin
        test_masks();
        test_counts();
        test_hdb3();
        test_cv();
        test_saturate();
        conclude();
    end
endmodule
